/* File: src/gpio_pkg.sv */
package gpio_pkg;

   // ----------------------------------------
   // Port size and register map
   // ----------------------------------------
   localparam int unsigned NPIN = 8;
   localparam int unsigned CFG_W = 7;
   localparam logic [7:0] OFF_DIR = 8'h00;
   localparam logic [7:0] OFF_DIRSET = 8'h04;
   localparam logic [7:0] OFF_DIRCLR = 8'h08;
   localparam logic [7:0] OFF_DIRTGL = 8'h0c;
   localparam logic [7:0] OFF_OUT = 8'h10;
   localparam logic [7:0] OFF_OUTSET = 8'h14;
   localparam logic [7:0] OFF_OUTCLR = 8'h18;
   localparam logic [7:0] OFF_OUTTGL = 8'h1c;
   localparam logic [7:0] OFF_IN = 8'h20;
   localparam logic [7:0] OFF_INTCTRL = 8'h24;
   localparam logic [7:0] OFF_INT0MSK = 8'h28;
   localparam logic [7:0] OFF_INT1MSK = 8'h2c;
   localparam logic [7:0] OFF_INTFLG = 8'h30;
   localparam logic [7:0] OFF_MPCMSK = 8'h34;
   localparam logic [7:0] OFF_OUTSEL = 8'h38;
   localparam logic [7:0] OFF_CFG0 = 8'h40;
   localparam logic [7:0] OFF_CFG7 = 8'h5c;

   // ----------------------------------------
   // Fields and codes
   // ----------------------------------------
   localparam int unsigned SNS_LSB = 0;
   localparam int unsigned MODE_LSB = 3;
   localparam int unsigned INV_BIT = 6;
   localparam int unsigned LVL0_LSB = 0;
   localparam int unsigned LVL1_LSB = 2;
   localparam logic [1:0] SNS_BOTH = 2'h0;
   localparam logic [1:0] SNS_RISE = 2'h1;
   localparam logic [1:0] SNS_FALL = 2'h2;
   localparam logic [1:0] SNS_LOW = 2'h3;
   localparam logic [2:0] MD_TOTEM = 3'h0;
   localparam logic [2:0] MD_KEEP = 3'h1;
   localparam logic [2:0] MD_PD = 3'h2;
   localparam logic [2:0] MD_PU = 3'h3;
   localparam logic [2:0] MD_WOR = 3'h4;
   localparam logic [2:0] MD_WAND = 3'h5;
   localparam logic [2:0] MD_WORPD = 3'h6;
   localparam logic [2:0] MD_WANDPU = 3'h7;
   localparam logic [1:0] OSEL_NONE = 2'h0;
   localparam logic [1:0] OSEL_CLK = 2'h1;
   localparam logic [1:0] OSEL_EV = 2'h2;
   localparam int unsigned OSEL_PIN = 7;

   // ----------------------------------------
   // Reset values and vectors
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [6:0] RST_CFG = 7'h00;
   localparam logic [11:0] VEC_PORT_C = 12'h004;
   localparam logic [11:0] VEC_PORT_R = 12'h008;
   localparam logic [11:0] VEC_INT1_OFF = 12'h002;

endpackage

/* File: src/gpio_port.sv */
// Functional notes
// - Eight pins, each configured on its own.
// - Each pin is input or output.
// - One write configures several pins.
// - Inversion applies from pin to input register.
// - Inversion applies from output register to pin.
// - Inversion also covers alternate pin functions.
// - Totem, pull, wired-AND, wired-OR, bus-keeper drives.
// - Bus-keeper weakly holds the last level.
// - Sense both, rising, falling edges or low.
// - Sync sensing with port clock, else async.
// - Inversion applies before sensing.
// - Every sense setting can raise wake-up.
// - Two port interrupts with own priority, vector.
// - Per-pin mask for each interrupt.
// - Masked pin detection fires the interrupt.
// - Toggle, clear, set ports for output, direction.
// - Event channel 0 may drive pin 7.
// - A clock may drive out on a pin.
// - Vector is base plus interrupt word offset.
// - Port C base 0x004, port R 0x008.
// - Priority is high, medium or low.
`timescale 1ns/100ps
`default_nettype none

module gpio_port #(
   parameter bit PORT_IS_R = 1'b0
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] port_pin_n_in,
   output logic [7:0] port_pin_n_out,
   output logic [7:0] port_pin_n_oe,
   output logic [7:0] port_pin_n_pu,
   output logic [7:0] port_pin_n_pd,
   input wire logic [7:0] alt_en,
   input wire logic [7:0] alt_out,
   input wire logic [7:0] alt_oe,
   input wire logic ev_ch0,
   input wire logic port_clk_en,
   output logic [7:0] pin_value,
   output logic [7:0] pin_event,
   output logic [1:0] irq,
   output logic [1:0] irq0_level,
   output logic [1:0] irq1_level,
   output logic wake,
   output logic [11:0] int0_vector,
   output logic [11:0] int1_vector
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] out;
      logic [7:0] mpc;
      logic [7:0] msk0;
      logic [7:0] msk1;
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] prev;
      logic [7:0] snap;
      logic [7:0] keep;
      logic [7:0] pinev;
      logic [7:0][6:0] cfg;
      logic [3:0] ictl;
      logic [1:0] flg;
      logic [1:0] osel;
      logic cdiv;
      logic [31:0] rdata;
   } gpio_st_t;

   gpio_st_t st_q;
   gpio_st_t st_d;
   logic [7:0] val;
   logic [7:0] det;
   logic [7:0] ahit;
   logic [7:0] inv;
   logic [7:0] drv;
   logic [2:0] cfg_idx;
   logic wr_acc;
   logic rd_setup;
   logic addr_ok;
   logic cfg_sel;

   // ----------------------------------------
   // Per-pin drive and sensing
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < gpio_pkg::NPIN; gi++)
      begin : g_pin
         logic [2:0] mode;
         logic [1:0] sns;
         logic src;
         logic de;
         logic o;
         logic cmp;
         assign mode = st_q.cfg[gi][gpio_pkg::MODE_LSB +: 3];
         assign sns = st_q.cfg[gi][gpio_pkg::SNS_LSB +: 2];
         assign inv[gi] = st_q.cfg[gi][gpio_pkg::INV_BIT];
         // The synchronised level is the only pin view that logic reads.
         assign val[gi] = st_q.s2[gi] ^ inv[gi];
         assign cmp = port_clk_en ? st_q.prev[gi] : st_q.snap[gi];

         always_comb
         begin
            case (sns)
               gpio_pkg::SNS_BOTH: ahit[gi] = val[gi] ^ cmp;
               gpio_pkg::SNS_RISE: ahit[gi] = val[gi] & ~cmp;
               gpio_pkg::SNS_FALL: ahit[gi] = ~val[gi] & cmp;
               default: ahit[gi] = ~val[gi];
            endcase
         end
         assign det[gi] = ahit[gi] & port_clk_en;

         always_comb
         begin
            src = alt_en[gi] ? alt_out[gi] : st_q.out[gi];
            de = alt_en[gi] ? alt_oe[gi] : st_q.dir[gi];
            if (gi == gpio_pkg::OSEL_PIN && st_q.osel != gpio_pkg::OSEL_NONE)
            begin
               src = (st_q.osel == gpio_pkg::OSEL_CLK) ? st_q.cdiv : ev_ch0;
               de = 1'b1;
            end
            o = src ^ inv[gi];
            drv[gi] = o;
            port_pin_n_out[gi] = o;
            port_pin_n_oe[gi] = de;
            port_pin_n_pu[gi] = 1'b0;
            port_pin_n_pd[gi] = 1'b0;
            case (mode)
               gpio_pkg::MD_TOTEM: ;
               gpio_pkg::MD_KEEP:
               begin
                  port_pin_n_pu[gi] = ~de & st_q.keep[gi];
                  port_pin_n_pd[gi] = ~de & ~st_q.keep[gi];
               end
               gpio_pkg::MD_PD: port_pin_n_pd[gi] = ~de;
               gpio_pkg::MD_PU: port_pin_n_pu[gi] = ~de;
               gpio_pkg::MD_WOR, gpio_pkg::MD_WORPD:
               begin
                  port_pin_n_out[gi] = 1'b1;
                  port_pin_n_oe[gi] = de & o;
                  port_pin_n_pd[gi] = (mode == gpio_pkg::MD_WORPD) & ~(de & o);
               end
               default:
               begin
                  port_pin_n_out[gi] = 1'b0;
                  port_pin_n_oe[gi] = de & ~o;
                  port_pin_n_pu[gi] = (mode == gpio_pkg::MD_WANDPU) & ~(de & ~o);
               end
            endcase
         end
      end
   endgenerate

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign wr_acc = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign cfg_sel = (paddr >= gpio_pkg::OFF_CFG0) && (paddr <= gpio_pkg::OFF_CFG7) && (paddr[1:0] == 2'h0);
   assign cfg_idx = paddr[4:2];
   assign addr_ok = cfg_sel || ((paddr <= gpio_pkg::OFF_OUTSEL) && (paddr[1:0] == 2'h0));

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      st_d = st_q;
      st_d.s1 = port_pin_n_in;
      st_d.s2 = st_q.s1;
      st_d.prev = val;
      // The snapshot freezes while the port clock is off, so a change is still seen.
      st_d.snap = port_clk_en ? val : st_q.snap;
      for (int k = 0; k < gpio_pkg::NPIN; k++)
      begin
         st_d.keep[k] = port_pin_n_oe[k] ? drv[k] : st_q.s2[k];
      end
      st_d.pinev = det;
      st_d.cdiv = ~st_q.cdiv;
      if (wr_acc)
      begin
         case (paddr)
            gpio_pkg::OFF_DIR: st_d.dir = pwdata[7:0];
            gpio_pkg::OFF_DIRSET: st_d.dir = st_q.dir | pwdata[7:0];
            gpio_pkg::OFF_DIRCLR: st_d.dir = st_q.dir & ~pwdata[7:0];
            gpio_pkg::OFF_DIRTGL: st_d.dir = st_q.dir ^ pwdata[7:0];
            gpio_pkg::OFF_OUT: st_d.out = pwdata[7:0];
            gpio_pkg::OFF_OUTSET: st_d.out = st_q.out | pwdata[7:0];
            gpio_pkg::OFF_OUTCLR: st_d.out = st_q.out & ~pwdata[7:0];
            gpio_pkg::OFF_OUTTGL: st_d.out = st_q.out ^ pwdata[7:0];
            gpio_pkg::OFF_INTCTRL: st_d.ictl = pwdata[3:0];
            gpio_pkg::OFF_INT0MSK: st_d.msk0 = pwdata[7:0];
            gpio_pkg::OFF_INT1MSK: st_d.msk1 = pwdata[7:0];
            gpio_pkg::OFF_MPCMSK: st_d.mpc = pwdata[7:0];
            gpio_pkg::OFF_OUTSEL: st_d.osel = pwdata[1:0];
            default: ;
         endcase
         if (cfg_sel)
         begin
            for (int k = 0; k < gpio_pkg::NPIN; k++)
            begin
               if (st_q.mpc != 8'h00 ? st_q.mpc[k] : (cfg_idx == 3'(k)))
               begin
                  st_d.cfg[k] = pwdata[6:0];
               end
            end
            // The multi-pin mask is single use, so a stale mask never spreads a later write.
            st_d.mpc = 8'h00;
         end
      end
      // A detection in the clearing cycle keeps its flag set.
      st_d.flg[0] = st_q.flg[0] & ~(wr_acc && paddr == gpio_pkg::OFF_INTFLG && pwdata[0]);
      st_d.flg[1] = st_q.flg[1] & ~(wr_acc && paddr == gpio_pkg::OFF_INTFLG && pwdata[1]);
      st_d.flg[0] = st_d.flg[0] | (|(det & st_q.msk0));
      st_d.flg[1] = st_d.flg[1] | (|(det & st_q.msk1));
      if (rd_setup)
      begin
         st_d.rdata = 32'h0000_0000;
         if (cfg_sel)
         begin
            st_d.rdata[6:0] = st_q.cfg[cfg_idx];
         end
         else
         begin
            case (paddr)
               gpio_pkg::OFF_DIR: st_d.rdata[7:0] = st_q.dir;
               gpio_pkg::OFF_OUT: st_d.rdata[7:0] = st_q.out;
               gpio_pkg::OFF_IN: st_d.rdata[7:0] = val;
               gpio_pkg::OFF_INTCTRL: st_d.rdata[3:0] = st_q.ictl;
               gpio_pkg::OFF_INT0MSK: st_d.rdata[7:0] = st_q.msk0;
               gpio_pkg::OFF_INT1MSK: st_d.rdata[7:0] = st_q.msk1;
               gpio_pkg::OFF_INTFLG: st_d.rdata[1:0] = st_q.flg;
               gpio_pkg::OFF_MPCMSK: st_d.rdata[7:0] = st_q.mpc;
               gpio_pkg::OFF_OUTSEL: st_d.rdata[1:0] = st_q.osel;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= '0;
         st_q.dir <= gpio_pkg::RST_BYTE;
         st_q.out <= gpio_pkg::RST_BYTE;
         st_q.cfg <= {gpio_pkg::NPIN{gpio_pkg::RST_CFG}};
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = st_q.rdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign pin_value = st_q.prev;
   assign pin_event = st_q.pinev;
   assign irq0_level = st_q.ictl[gpio_pkg::LVL0_LSB +: 2];
   assign irq1_level = st_q.ictl[gpio_pkg::LVL1_LSB +: 2];
   assign irq[0] = st_q.flg[0] & (irq0_level != 2'h0);
   assign irq[1] = st_q.flg[1] & (irq1_level != 2'h0);
   // Wake-up needs no port clock edge once the snapshot is frozen.
   assign wake = ~port_clk_en & (|(ahit & (st_q.msk0 | st_q.msk1)));
   assign int0_vector = PORT_IS_R ? gpio_pkg::VEC_PORT_R : gpio_pkg::VEC_PORT_C;
   assign int1_vector = int0_vector + gpio_pkg::VEC_INT1_OFF;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_DIR_SET: assert property (wr_acc && paddr == gpio_pkg::OFF_DIRSET |=> st_q.dir == ($past(st_q.dir) | $past(pwdata[7:0]))) else $error("dir set wrong");
   AST_OUT_CLR: assert property (wr_acc && paddr == gpio_pkg::OFF_OUTCLR |=> st_q.out == ($past(st_q.out) & ~$past(pwdata[7:0]))) else $error("out clear wrong");
   AST_INV_OUT: assert property (st_q.dir[0] && !alt_en[0] && g_pin[0].mode == gpio_pkg::MD_TOTEM |-> port_pin_n_oe[0] && port_pin_n_out[0] == (st_q.out[0] ^ inv[0])) else $error("pin 0 drive wrong");
   AST_IN_READ: assert property (rd_setup && paddr == gpio_pkg::OFF_IN |=> prdata[7:0] == ($past(st_q.s2) ^ $past(inv))) else $error("input read wrong");
   AST_INT_FLAG: assert property (det[0] && st_q.msk0[0] ##1 !(wr_acc && paddr == gpio_pkg::OFF_INTFLG) |-> st_q.flg[0]) else $error("flag missed");
   AST_LOW_HOLD: assert property (port_clk_en && st_q.msk1[2] && g_pin[2].sns == gpio_pkg::SNS_LOW && !val[2] && irq1_level != 2'h0 |=> irq[1]) else $error("low request dropped");
   AST_KEEP: assert property (g_pin[1].mode == gpio_pkg::MD_KEEP && !st_q.dir[1] && !alt_en[1] |-> !port_pin_n_oe[1] && port_pin_n_pu[1] == st_q.keep[1] && port_pin_n_pd[1] == !st_q.keep[1]) else $error("keeper wrong");
   AST_EV_PIN7: assert property (st_q.osel == gpio_pkg::OSEL_EV && g_pin[7].mode == gpio_pkg::MD_TOTEM |-> port_pin_n_oe[7] && port_pin_n_out[7] == (ev_ch0 ^ inv[7])) else $error("event out wrong");
   AST_CLK_PIN7: assert property ((st_q.osel == gpio_pkg::OSEL_CLK && g_pin[7].mode == gpio_pkg::MD_TOTEM && $stable(inv[7]))[*2] |-> port_pin_n_out[7] != $past(port_pin_n_out[7])) else $error("clock out stuck");
   AST_MULTI_CFG: assert property (wr_acc && cfg_sel && st_q.mpc == 8'hff |=> st_q.cfg[0] == $past(pwdata[6:0]) && st_q.cfg[7] == $past(pwdata[6:0])) else $error("multi config wrong");
   AST_WAKE: assert property (!port_clk_en && st_q.msk0[3] && g_pin[3].sns == gpio_pkg::SNS_LOW && !val[3] |-> wake) else $error("wake missing");
   AST_VECTOR: assert property (int1_vector == int0_vector + 12'h002 && int0_vector == (PORT_IS_R ? 12'h008 : 12'h004)) else $error("vector wrong");

endmodule

`default_nettype wire

/* File: dv/gpio_pad_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// External pad circuitry
// ----------------------------------------
module gpio_pad_model (
   input wire logic clk,
   input wire logic [7:0] dev_out,
   input wire logic [7:0] dev_oe,
   input wire logic [7:0] dev_pu,
   input wire logic [7:0] dev_pd,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_oe,
   output logic [7:0] pad
);
   logic [7:0] last_q = 8'h00;

   // A floating pad shows the inverse of its last level, so a stale value never passes for a driven one.
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (ext_oe[i])
            pad[i] = ext_val[i];
         else if (dev_oe[i])
            pad[i] = dev_out[i];
         else if (dev_pu[i] || dev_pd[i])
            pad[i] = dev_pu[i];
         else
            pad[i] = ~last_q[i];
      end
   end

   always_ff @(posedge clk)
   begin
      last_q <= pad;
   end
endmodule

`default_nettype wire

/* File: dv/tb_general_purpose_io_port.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module tb_general_purpose_io_port;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, wake;
   logic [7:0] pad, pout, poe, ppu, ppd;
   logic [7:0] ext_val = 8'h00, ext_oe = 8'h00, alt_zero = 8'h00;
   logic ev_ch0 = 1'b0;
   logic clk_en = 1'b1;
   logic [1:0] irq;
   logic [11:0] vec0, vec1;
   logic [1:0] obs_sel = 2'h0;
   logic obs_req = 1'b0;
   logic [32:0] obs, got;
   logic [32:0] exp_q[$];
   int failures = 0;
   int tests_run = 0;
   logic [7:0] m_dir, m_out, r, t;
   logic [6:0] cfg_t[5] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h41};
   logic [4:0] pre_t = 5'b01000;
   logic [4:0] rise_t = 5'b01011;
   logic [4:0] fall_t = 5'b11101;

   gpio_port #(.PORT_IS_R(1'b0)) uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_pin_n_in(pad), .port_pin_n_out(pout), .port_pin_n_oe(poe), .port_pin_n_pu(ppu),
      .port_pin_n_pd(ppd), .alt_en(alt_zero), .alt_out(alt_zero), .alt_oe(alt_zero), .ev_ch0(ev_ch0),
      .port_clk_en(clk_en), .pin_value(), .pin_event(), .irq(irq), .irq0_level(), .irq1_level(),
      .wake(wake), .int0_vector(vec0), .int1_vector(vec1));

   gpio_pad_model pads (.clk(clk), .dev_out(pout), .dev_oe(poe), .dev_pu(ppu), .dev_pd(ppd),
      .ext_val(ext_val), .ext_oe(ext_oe), .pad(pad));

   always #5 clk = ~clk;

   always_comb
   begin
      case (obs_sel)
         2'h0: obs = {17'h0, poe, pout};
         2'h1: obs = {30'h0, wake, irq};
         default: obs = {9'h0, vec1, vec0};
      endcase
      got = obs_req ? obs : {pslverr, prdata};
   end

   // ----------------------------------------
   // Watcher: oldest note against each result
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (obs_req || (psel && penable && pready && !pwrite))
         `CHK(got, exp_q.pop_front())
   end

   // ----------------------------------------
   // Bus and observation tasks
   // ----------------------------------------
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      if (!wr)
         exp_q.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (n == 16)
      begin
         failures++;
         test_done();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask

   task automatic see(input logic [1:0] s, input logic [32:0] e);
      exp_q.push_back(e);
      obs_sel <= s;
      obs_req <= 1'b1;
      @(posedge clk);
      obs_req <= 1'b0;
      @(posedge clk);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      void'($urandom(32443));
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(gpio_pkg::OFF_DIR, 33'h0);
      rd(gpio_pkg::OFF_CFG0, 33'h0);
      see(2'h0, 33'h0);
      $display("test reset done");
      m_dir = 8'h00;
      m_out = 8'h00;
      for (int b = 0; b < 2; b++)
      begin
         for (int k = 1; k < 4; k++)
         begin
            r = 8'($urandom_range(255));
            wr(gpio_pkg::OFF_DIR + 8'(16 * b + 4 * k), {24'h0, r});
            t = b ? m_out : m_dir;
            t = (k == 1) ? (t | r) : (k == 2) ? (t & ~r) : (t ^ r);
            if (b == 0)
               m_dir = t;
            else
               m_out = t;
         end
      end
      rd(gpio_pkg::OFF_DIR, {25'h0, m_dir});
      rd(gpio_pkg::OFF_OUT, {25'h0, m_out});
      see(2'h0, {17'h0, m_dir, m_out});
      $display("test set clear toggle done");
      wr(gpio_pkg::OFF_DIR, 32'hff);
      wr(gpio_pkg::OFF_MPCMSK, 32'hf0);
      wr(gpio_pkg::OFF_CFG0 + 8'h10, 32'h40);
      rd(gpio_pkg::OFF_CFG7, 33'h40);
      rd(gpio_pkg::OFF_CFG0 + 8'h0c, 33'h0);
      see(2'h0, {17'h0, 8'hff, m_out ^ 8'hf0});
      rd(gpio_pkg::OFF_IN, {25'h0, m_out});
      wr(gpio_pkg::OFF_MPCMSK, 32'hff);
      wr(gpio_pkg::OFF_CFG0, 32'h0);
      $display("test inversion done");
      wr(gpio_pkg::OFF_DIR, 32'h0);
      ext_oe <= 8'hff;
      ext_val <= 8'h00;
      wr(gpio_pkg::OFF_INT0MSK, 32'h1);
      wr(gpio_pkg::OFF_INTCTRL, 32'h3);
      for (int i = 0; i < 5; i++)
      begin
         wr(gpio_pkg::OFF_CFG0, {25'h0, cfg_t[i]});
         repeat (4) @(posedge clk);
         wr(gpio_pkg::OFF_INTFLG, 32'h3);
         rd(gpio_pkg::OFF_INTFLG, {32'h0, pre_t[i]});
         ext_val <= 8'h01;
         repeat (5) @(posedge clk);
         rd(gpio_pkg::OFF_INTFLG, {32'h0, rise_t[i]});
         see(2'h1, {32'h0, rise_t[i]});
         wr(gpio_pkg::OFF_INTFLG, 32'h3);
         ext_val <= 8'h00;
         repeat (5) @(posedge clk);
         rd(gpio_pkg::OFF_INTFLG, {32'h0, fall_t[i]});
      end
      $display("test sensing done");
      rd(8'h3c, 33'h100000000);
      see(2'h2, {9'h0, 12'h006, 12'h004});
      ext_oe <= 8'h00;
      wr(gpio_pkg::OFF_DIR, 32'hff);
      wr(gpio_pkg::OFF_OUTSEL, {30'h0, gpio_pkg::OSEL_EV});
      ev_ch0 <= 1'b1;
      // Pin 0 still carries the inverted rise setting from the sensing loop.
      see(2'h0, {17'h0, 8'hff, 1'b1, m_out[6:0] ^ 7'h01});
      ev_ch0 <= 1'b0;
      see(2'h0, {17'h0, 8'hff, 1'b0, m_out[6:0] ^ 7'h01});
      $display("test vectors and event done");
      wr(gpio_pkg::OFF_OUTSEL, {30'h0, gpio_pkg::OSEL_CLK});
      repeat (4) @(posedge clk);
      ext_oe <= 8'h01;
      ext_val <= 8'h00;
      wr(gpio_pkg::OFF_CFG0, {25'h0, gpio_pkg::RST_CFG | 7'h03});
      clk_en <= 1'b0;
      wr(gpio_pkg::OFF_INTFLG, 32'h3);
      see(2'h1, {30'h0, 1'b1, 2'b00});
      clk_en <= 1'b1;
      $display("test clock out and wake done");
      test_done();
   end
endmodule

`default_nettype wire
